// ---- rtl/nic_arbiter.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "nic_defs.svh"

module nic_arbiter (
	input  wire logic [13:0] req,
	input  wire logic [13:0] allow,
	input  wire logic [31:0] prio,
	input  wire logic [1:0]  cur_level,
	output logic             win,
	output logic [3:0]       win_idx,
	output logic [1:0]       win_code
);

	// Emergency stop ranks 4 so it passes even a level 3 program.
	always_comb begin
		logic [2:0] best;
		logic [2:0] num;
		logic [2:0] cur;
		best = 3'h0;
		num = 3'h0;
		cur = {1'b0, nic_pkg::nic_rank(cur_level)};
		win = 1'b0;
		win_idx = 4'h0;
		win_code = `NIC_LVL3;
		for (int v = 0; v < 14; v++) begin
			// The emergency field is storage only.
			num = (v == 0) ? 3'h4 : {1'b0, nic_pkg::nic_rank(prio[2*v +: 2])};
			// Ascending scan with strict compare keeps the lower vector on a tie.
			if (req[v] && allow[v] && num > cur && (!win || num > best)) begin
				win = 1'b1;
				best = num;
				win_idx = 4'(v);
				win_code = (v == 0) ? `NIC_LVL3 : prio[2*v +: 2];
			end
		end
	end

endmodule
`default_nettype wire

// ---- rtl/nic_defs.svh ----
`ifndef NIC_DEFS_SVH
`define NIC_DEFS_SVH

// Register indices; the byte address is four times the index.
`define NIC_IDX_PRIO0   10'h024
`define NIC_IDX_PRIO3   10'h027
`define NIC_IDX_EXT_SENSE_CONTROL_REG    10'h028
`define NIC_IDX_MMASK   10'h029
`define NIC_IDX_LEVEL   10'h02A
`define NIC_IDX_PEND    10'h02B

`define NIC_PRIO_RST    8'hFF
`define NIC_EXT_SENSE_CONTROL_REG_RST    8'h00
`define NIC_LVL0        2'h2
`define NIC_LVL3        2'h3

// Field positions inside the sense control, condition-code and emergency mask bytes.
`define NIC_IPA         0
`define NIC_IS0_LSB     1
`define NIC_IS1_LSB     3
`define NIC_IPB         5
`define NIC_IS2_LSB     6
`define NIC_CC_HI       5
`define NIC_CC_LO       3
`define NIC_EIM         0

`define NIC_VEC_RESET   16'hFFFE
`define NIC_VEC_TRAP    16'hFFFC
`define NIC_VEC_TOP     16'hFFFA

`define NIC_ALL_VECS    14'h3FFF
`define NIC_HALT_EXIT   14'h111C
`define NIC_AHALT_EXIT  14'h111E
`define NIC_PERIPH_VECS 14'h3FE2
`define NIC_LINE0_PINS  10'h007
`define NIC_LINE1_PINS  10'h078
`define NIC_LINE2_PINS  10'h380

`define NIC_RESP_OKAY   2'h0
`define NIC_RESP_SLVERR 2'h2

`endif

// ---- rtl/nic_pkg.sv ----
package nic_pkg;

	typedef enum logic [3:0] {
		NIC_RUN   = 4'h1,
		NIC_WAIT  = 4'h2,
		NIC_HALT  = 4'h4,
		NIC_AHALT = 4'h8
	} nic_mode_t;

	typedef enum logic [2:0] {
		NIC_OP_NONE  = 3'h0,
		NIC_OP_EI    = 3'h1,
		NIC_OP_DI    = 3'h2,
		NIC_OP_TRAP  = 3'h3,
		NIC_OP_HALT  = 3'h4,
		NIC_OP_WFI   = 3'h5,
		NIC_OP_IRQ_RETURN_INSTR  = 3'h6,
		NIC_OP_POPCC = 3'h7
	} nic_op_t;

	typedef struct packed {
		logic       instr_end;
		nic_op_t    op;
		logic [7:0] cc;
	} nic_cpu_cmd_t;

	typedef struct packed {
		logic        strobe;
		logic [15:0] vector;
		logic [1:0]  level;
	} nic_service_t;

	// Level code to its rank: main 0 up to disable 3.
	function automatic logic [1:0] nic_rank(input logic [1:0] code);
		case (code)
			2'h2: nic_rank = 2'h0;
			2'h1: nic_rank = 2'h1;
			2'h0: nic_rank = 2'h2;
			default: nic_rank = 2'h3;
		endcase
	endfunction

	// Returns {level hit, edge hit} for one pin.
	function automatic logic [1:0] nic_sense(input logic [1:0] code, input logic inv,
		input logic cur, input logic prev);
		logic rise;
		logic fall;
		rise = inv ? (prev & ~cur) : (cur & ~prev);
		fall = inv ? (cur & ~prev) : (prev & ~cur);
		case (code)
			2'h0: nic_sense = {(inv ? cur : ~cur), fall};
			2'h1: nic_sense = {1'b0, rise};
			2'h2: nic_sense = {1'b0, fall};
			default: nic_sense = {1'b0, rise | fall};
		endcase
	endfunction

endpackage

// ---- rtl/nic_top.sv ----
// The implementer's own choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ns
`default_nettype none
`include "nic_defs.svh"

// How it works
// - Reset outranks all, runs at level 3.
// - Maskable needs enable and higher level; else pending.
// - Emergency on edge or speed error; held low.
// - External edge latch clears on service entry.
// - Selected pins of one line are ORed.
// - Peripheral request needs flag and enable.
// - Clear sequence discards the pending latch.
// - Any request ends wait; halt exit restricted.
// - Blocked higher source follows the wake routine.
// - Lower vector wins among equal levels.
// - Level held as two condition-code bits.
// - Service entry loads the vector's level.
// - Reset, trap, emergency pass level 3, set 11.
// - Four priority bytes; top nibble reads ones.
// - Writing level 0 keeps the old field.
// - Emergency field stored but not arbitrated.
// - Raised level inside routine allows re-entry.
// - Instructions load, clear or restore level bits.
// - Vectors descend two bytes from emergency stop.
// - Time-base source ends active-halt only.
// - Changed sense settings clear external pending.
// - Forced-low interrupt pin masks its line.
// - Service only at instruction end.
// - Non-maskable sources ignore level; the halt masks leave out emergency, so it cannot wake halt.
module nic_top (
	input  wire logic                  CLK,
	input  wire logic                  NRST,
	input  wire logic                  AWVALID,
	output logic                       AWREADY,
	input  wire logic [11:0]           AWADDR,
	input  wire logic                  WVALID,
	output logic                       WREADY,
	input  wire logic [31:0]           WDATA,
	input  wire logic [3:0]            WSTRB,
	output logic                       BVALID,
	input  wire logic                  BREADY,
	output logic [1:0]                 BRESP,
	input  wire logic                  ARVALID,
	output logic                       ARREADY,
	input  wire logic [11:0]           ARADDR,
	output logic                       RVALID,
	input  wire logic                  RREADY,
	output logic [31:0]                RDATA,
	output logic [1:0]                 RRESP,
	input  wire nic_pkg::nic_cpu_cmd_t CPU_CMD,
	output nic_pkg::nic_service_t      SERVICE,
	output logic                       CURRENT_LEVEL_HI,
	output logic                       CURRENT_LEVEL_LO,
	output logic                       WAKE,
	input  wire logic [9:0]            EXT_PINS,
	input  wire logic [9:0]            EXT_PIN_IRQ_EN,
	input  wire logic [9:0]            EXT_PIN_FORCED,
	input  wire logic                  EMERGENCY_PIN,
	input  wire logic                  SPEED_ERR,
	input  wire logic [13:0]           PERIPH_FLAG,
	input  wire logic [13:0]           PERIPH_EN,
	input  wire logic [13:0]           PERIPH_CLR,
	input  wire logic                  ACTIVE_HALT_SEL
);

	localparam logic [9:0] LINE_PINS [3] = '{`NIC_LINE0_PINS, `NIC_LINE1_PINS, `NIC_LINE2_PINS};
	localparam int         SENSE_LSB [3] = '{`NIC_IS0_LSB, `NIC_IS1_LSB, `NIC_IS2_LSB};

	logic [9:0]          pin_s1;
	logic [9:0]          pin_s2;
	logic [9:0]          pin_prev;
	logic                em_s1;
	logic                em_s2;
	logic                em_prev;
	logic [7:0]          prio [4];
	logic [31:0]         prio_flat;
	logic [7:0]          ext_sense_control_reg;
	logic                emergency_irq_enable;
	logic [1:0]          cur_level;
	nic_pkg::nic_mode_t  mode;
	logic [13:0]         halt_mask;
	logic                rst_svc;
	logic [2:0]          ext_pend;
	logic [2:0]          edge_hit;
	logic [2:0]          lvl_hit;
	logic [2:0]          forced;
	logic [2:0]          ext_req;
	logic                em_pend;
	logic [13:0]         per_latch;
	logic [13:0]         per_set;
	logic [13:0]         req;
	logic                win;
	logic [3:0]          win_idx;
	logic [1:0]          win_code;
	logic                trap;
	logic                take;
	logic                aw_held;
	logic                w_held;
	logic [9:0]          aw_idx;
	logic [7:0]          wdata_h;
	logic                wstrb_h;
	logic                do_write;
	logic                wr_en;
	logic                ext_sense_control_reg_changed;
	logic                next_aw_held;
	logic                next_w_held;
	logic                next_bvalid;
	logic                next_rvalid;
	logic [31:0]         rd_word;

	function automatic logic mapped(input logic [9:0] idx);
		mapped = idx >= `NIC_IDX_PRIO0 && idx <= `NIC_IDX_PEND;
	endfunction

	// Pins and the emergency input are asynchronous to CLK.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			pin_s1 <= 10'h3FF;
			pin_s2 <= 10'h3FF;
			pin_prev <= 10'h3FF;
			em_s1 <= 1'b1;
			em_s2 <= 1'b1;
			em_prev <= 1'b1;
		end else begin
			pin_s1 <= EXT_PINS;
			pin_s2 <= pin_s1;
			pin_prev <= pin_s2;
			em_s1 <= EMERGENCY_PIN;
			em_s2 <= em_s1;
			em_prev <= em_s2;
		end
	end

	for (genvar l = 0; l < 3; l++) begin : g_line
		logic [1:0] code;
		logic       inv;
		assign code = ext_sense_control_reg[SENSE_LSB[l] +: 2];
		assign inv = (l == 0) ? ext_sense_control_reg[`NIC_IPA]
			: (l == 2) ? ext_sense_control_reg[`NIC_IPB] : 1'b0;
		always_comb begin
			logic [1:0] hit;
			hit = 2'h0;
			edge_hit[l] = 1'b0;
			lvl_hit[l] = 1'b0;
			forced[l] = 1'b0;
			for (int p = 0; p < 10; p++) begin
				if (LINE_PINS[l][p] && EXT_PIN_IRQ_EN[p]) begin
					hit = nic_pkg::nic_sense(code, inv, pin_s2[p], pin_prev[p]);
					edge_hit[l] = edge_hit[l] | hit[0];
					lvl_hit[l] = lvl_hit[l] | hit[1];
					forced[l] = forced[l] | EXT_PIN_FORCED[p];
				end
			end
		end
		assign ext_req[l] = ~forced[l] & (ext_pend[l] | lvl_hit[l]);
	end

	assign per_set = PERIPH_FLAG & PERIPH_EN & `NIC_PERIPH_VECS;
	assign req = (per_latch & PERIPH_EN & `NIC_PERIPH_VECS)
		| {9'h000, ext_req, 2'h0}
		| {13'h0000, emergency_irq_enable & (em_pend | ~em_s2)};

	// A change of priority takes effect at once, so a pending re-raise re-enters.
	assign prio_flat = {prio[3], prio[2], prio[1], prio[0]};

	nic_arbiter u_arb (
		.req       (req),
		.allow     (halt_mask),
		.prio      (prio_flat),
		.cur_level (cur_level),
		.win       (win),
		.win_idx   (win_idx),
		.win_code  (win_code)
	);

	assign trap = CPU_CMD.instr_end && CPU_CMD.op == nic_pkg::NIC_OP_TRAP && !rst_svc;
	assign take = CPU_CMD.instr_end && mode == nic_pkg::NIC_RUN && win && !trap && !rst_svc;

	// The reset routine is issued first after release, ahead of any source.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			rst_svc <= 1'b1;
		end else begin
			rst_svc <= 1'b0;
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			SERVICE.strobe <= 1'b0;
			SERVICE.vector <= `NIC_VEC_RESET;
			SERVICE.level <= `NIC_LVL3;
		end else begin
			SERVICE.strobe <= rst_svc | trap | take;
			if (rst_svc) begin
				SERVICE.vector <= `NIC_VEC_RESET;
				SERVICE.level <= `NIC_LVL3;
			end else if (trap) begin
				SERVICE.vector <= `NIC_VEC_TRAP;
				SERVICE.level <= `NIC_LVL3;
			end else if (take) begin
				SERVICE.vector <= `NIC_VEC_TOP - {11'h000, win_idx, 1'b0};
				SERVICE.level <= win_code;
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			cur_level <= `NIC_LVL3;
		end else if (rst_svc || trap) begin
			cur_level <= `NIC_LVL3;
		end else if (take) begin
			cur_level <= win_code;
		end else if (CPU_CMD.instr_end) begin
			case (CPU_CMD.op)
				nic_pkg::NIC_OP_EI: cur_level <= `NIC_LVL0;
				nic_pkg::NIC_OP_DI: cur_level <= `NIC_LVL3;
				nic_pkg::NIC_OP_HALT, nic_pkg::NIC_OP_WFI: cur_level <= `NIC_LVL0;
				nic_pkg::NIC_OP_IRQ_RETURN_INSTR, nic_pkg::NIC_OP_POPCC: begin
					cur_level <= {CPU_CMD.cc[`NIC_CC_HI], CPU_CMD.cc[`NIC_CC_LO]};
				end
				default: cur_level <= cur_level;
			endcase
		end
	end
	assign CURRENT_LEVEL_HI = cur_level[1];
	assign CURRENT_LEVEL_LO = cur_level[0];

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			mode <= nic_pkg::NIC_RUN;
			halt_mask <= `NIC_ALL_VECS;
			WAKE <= 1'b0;
		end else begin
			WAKE <= mode != nic_pkg::NIC_RUN && win;
			case (mode)
				nic_pkg::NIC_RUN: begin
					if (take) begin
						halt_mask <= `NIC_ALL_VECS;
					end else if (CPU_CMD.instr_end && !trap && !rst_svc) begin
						if (CPU_CMD.op == nic_pkg::NIC_OP_HALT) begin
							mode <= ACTIVE_HALT_SEL ? nic_pkg::NIC_AHALT : nic_pkg::NIC_HALT;
							halt_mask <= ACTIVE_HALT_SEL ? `NIC_AHALT_EXIT : `NIC_HALT_EXIT;
						end else if (CPU_CMD.op == nic_pkg::NIC_OP_WFI) begin
							mode <= nic_pkg::NIC_WAIT;
						end
					end
				end
				// The halt mask stays after wake so the first service is a capable source.
				nic_pkg::NIC_WAIT, nic_pkg::NIC_HALT, nic_pkg::NIC_AHALT: begin
					if (win) begin
						mode <= nic_pkg::NIC_RUN;
					end
				end
				default: mode <= nic_pkg::NIC_RUN;
			endcase
		end
	end

	// Every latch lets a new event win over its clear in the same cycle.
	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ext_pend <= 3'h0;
			em_pend <= 1'b0;
			per_latch <= 14'h0000;
		end else begin
			for (int l = 0; l < 3; l++) begin
				ext_pend[l] <= (ext_pend[l] & ~((take && win_idx == 4'(l + 2)) || ext_sense_control_reg_changed))
					| edge_hit[l];
			end
			em_pend <= (em_pend & ~(take && win_idx == 4'h0)) | (em_prev & ~em_s2) | SPEED_ERR;
			per_latch <= (per_latch & ~PERIPH_CLR) | per_set;
		end
	end

	assign do_write = aw_held && w_held && !BVALID;
	assign wr_en = do_write && wstrb_h;
	assign ext_sense_control_reg_changed = wr_en && aw_idx == `NIC_IDX_EXT_SENSE_CONTROL_REG && wdata_h != ext_sense_control_reg;
	assign next_aw_held = !do_write && (aw_held || (AWVALID && AWREADY));
	assign next_w_held = !do_write && (w_held || (WVALID && WREADY));
	assign next_bvalid = do_write || (BVALID && !BREADY);
	assign next_rvalid = (ARVALID && ARREADY) || (RVALID && !RREADY);

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			aw_held <= 1'b0;
			w_held <= 1'b0;
			aw_idx <= 10'h000;
			wdata_h <= 8'h00;
			wstrb_h <= 1'b0;
			AWREADY <= 1'b0;
			WREADY <= 1'b0;
			BVALID <= 1'b0;
			BRESP <= `NIC_RESP_OKAY;
		end else begin
			aw_held <= next_aw_held;
			w_held <= next_w_held;
			AWREADY <= !next_aw_held && !next_bvalid;
			WREADY <= !next_w_held && !next_bvalid;
			BVALID <= next_bvalid;
			if (AWVALID && AWREADY) begin
				aw_idx <= AWADDR[11:2];
			end
			if (WVALID && WREADY) begin
				wdata_h <= WDATA[7:0];
				wstrb_h <= WSTRB[0];
			end
			if (do_write) begin
				BRESP <= mapped(aw_idx) ? `NIC_RESP_OKAY : `NIC_RESP_SLVERR;
			end
		end
	end

	for (genvar r = 0; r < 4; r++) begin : g_prio
		always_ff @(posedge CLK or negedge NRST) begin
			if (!NRST) begin
				prio[r] <= `NIC_PRIO_RST;
			end else if (wr_en && aw_idx == 10'(`NIC_IDX_PRIO0 + r)) begin
				for (int f = 0; f < 4; f++) begin
					// The top nibble of the last byte never changes.
					if ((r < 3 || f < 2) && wdata_h[2*f +: 2] != `NIC_LVL0) begin
						prio[r][2*f +: 2] <= wdata_h[2*f +: 2];
					end
				end
			end
		end
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ext_sense_control_reg <= `NIC_EXT_SENSE_CONTROL_REG_RST;
			emergency_irq_enable <= 1'b0;
		end else if (wr_en) begin
			if (aw_idx == `NIC_IDX_EXT_SENSE_CONTROL_REG) begin
				ext_sense_control_reg <= wdata_h;
			end
			if (aw_idx == `NIC_IDX_MMASK) begin
				emergency_irq_enable <= wdata_h[`NIC_EIM];
			end
		end
	end

	always_comb begin
		case (ARADDR[11:2])
			`NIC_IDX_PRIO0:        rd_word = {24'h00_0000, prio[0]};
			`NIC_IDX_PRIO0 + 10'h1: rd_word = {24'h00_0000, prio[1]};
			`NIC_IDX_PRIO0 + 10'h2: rd_word = {24'h00_0000, prio[2]};
			`NIC_IDX_PRIO3:        rd_word = {24'h00_0000, prio[3]};
			`NIC_IDX_EXT_SENSE_CONTROL_REG:         rd_word = {24'h00_0000, ext_sense_control_reg};
			`NIC_IDX_MMASK:        rd_word = {31'h0000_0000, emergency_irq_enable};
			`NIC_IDX_LEVEL:        rd_word = {26'h000_0000, cur_level[1], 1'b0, cur_level[0], 3'h0};
			`NIC_IDX_PEND:         rd_word = {18'h0_0000, req};
			default:               rd_word = 32'h0000_0000;
		endcase
	end

	always_ff @(posedge CLK or negedge NRST) begin
		if (!NRST) begin
			ARREADY <= 1'b0;
			RVALID <= 1'b0;
			RDATA <= 32'h0000_0000;
			RRESP <= `NIC_RESP_OKAY;
		end else begin
			ARREADY <= !next_rvalid;
			RVALID <= next_rvalid;
			if (ARVALID && ARREADY) begin
				RDATA <= rd_word;
				RRESP <= mapped(ARADDR[11:2]) ? `NIC_RESP_OKAY : `NIC_RESP_SLVERR;
			end
		end
	end

	default clocking cb @(posedge CLK);
	endclocking
	default disable iff (!NRST);

	logic prio_has_l0;
	always_comb begin
		prio_has_l0 = 1'b0;
		for (int f = 0; f < 16; f++) begin
			prio_has_l0 = prio_has_l0 | (prio_flat[2*f +: 2] == `NIC_LVL0);
		end
	end

	a_boundary_only: assert property (SERVICE.strobe && !$past(rst_svc) |-> $past(CPU_CMD.instr_end))
		else $error("service issued outside an instruction end");
	a_emerg_level: assert property (take && win_idx == 4'h0 |=> SERVICE.vector == 16'hFFFA
		&& cur_level == 2'h3)
		else $error("emergency service did not set level 3");
	a_trap_entry: assert property (trap |=> SERVICE.strobe && SERVICE.vector == 16'hFFFC && cur_level == 2'h3)
		else $error("trap did not enter at level 3");
	a_enable_level: assert property (CPU_CMD.instr_end && CPU_CMD.op == nic_pkg::NIC_OP_EI && !take
		&& !rst_svc |=> cur_level == 2'h2)
		else $error("enable did not load level 0");
	a_level3_gate: assert property (cur_level == 2'h3 && win |-> win_idx == 4'h0)
		else $error("maskable source passed level 3");
	a_no_level0: assert property (!prio_has_l0)
		else $error("level 0 code stored in a priority field");
	a_top_nibble: assert property (ARVALID && ARREADY && ARADDR[11:2] == 10'h027 |=> RDATA[7:4] == 4'hF)
		else $error("top nibble of last priority byte not ones");
	a_halt_wake: assert property (mode == nic_pkg::NIC_HALT && win |=> mode == nic_pkg::NIC_RUN && WAKE
		&& halt_mask[$past(win_idx)])
		else $error("halt exit by an incapable source");
	a_clear_drops: assert property (##1 ((per_latch & $past(PERIPH_CLR & ~per_set)) == 14'h0000))
		else $error("peripheral latch survived its clear");
	a_resp_stable: assert property (BVALID && !BREADY |=> BVALID && $stable(BRESP))
		else $error("write response dropped before it was taken");

	c_emerg: cover property (take && win_idx == 4'h0);
	c_halt_wake: cover property (mode == nic_pkg::NIC_HALT ##1 mode == nic_pkg::NIC_RUN ##[1:20] SERVICE.strobe);
	c_nested: cover property (take ##[1:30] take && cur_level != 2'h2);
	c_ext_sense_control_reg_clear: cover property (ext_sense_control_reg_changed && ext_pend != 3'h0);

endmodule
`default_nettype wire

// ---- test/nested_priority_interrupt_controller_test.sv ----
`timescale 1ns/1ns
`default_nettype none
`include "nic_defs.svh"

module nested_priority_interrupt_controller_test;
	localparam logic [1:0] ok = `NIC_RESP_OKAY;
	localparam logic [1:0] err = `NIC_RESP_SLVERR;
	logic clk = 1'b0, nrst = 1'b0, go = 1'b0, slow = 1'b0, estop = 1'b1, speed_err = 1'b0;
	logic awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
	logic awready, wready, bvalid, arready, rvalid, lvl_hi, lvl_lo, wake;
	logic [11:0] awaddr = 12'h000, araddr = 12'h000;
	logic [31:0] wdata = 32'h0000_0000, rdata;
	logic [1:0] bresp, rresp, last_lvl;
	logic [7:0] cc = 8'h00;
	logic [9:0] pins = 10'h3FF, forced = 10'h000;
	logic [13:0] flag = 14'h0000, en = 14'h0000, clr = 14'h0000;
	logic [15:0] last_vec;
	nic_pkg::nic_cpu_cmd_t cmd;
	nic_pkg::nic_service_t service;
	nic_pkg::nic_op_t op = nic_pkg::NIC_OP_NONE;
	int srv_n, wake_n, n, w, n_errors = 0, comparisons = 0;

	always #20 clk = ~clk;

	nic_top dut (.CLK(clk), .NRST(nrst), .AWVALID(awvalid), .AWREADY(awready), .AWADDR(awaddr),
		.WVALID(wvalid), .WREADY(wready), .WDATA(wdata), .WSTRB(4'h1), .BVALID(bvalid),
		.BREADY(bready), .BRESP(bresp), .ARVALID(arvalid), .ARREADY(arready), .ARADDR(araddr),
		.RVALID(rvalid), .RREADY(rready), .RDATA(rdata), .RRESP(rresp), .CPU_CMD(cmd),
		.SERVICE(service), .CURRENT_LEVEL_HI(lvl_hi), .CURRENT_LEVEL_LO(lvl_lo), .WAKE(wake),
		.EXT_PINS(pins), .EXT_PIN_IRQ_EN(10'h078), .EXT_PIN_FORCED(forced), .EMERGENCY_PIN(estop),
		.SPEED_ERR(speed_err), .PERIPH_FLAG(flag), .PERIPH_EN(en), .PERIPH_CLR(clr),
		.ACTIVE_HALT_SEL(1'b0));

	nic_cpu_model cpu_side (.clk(clk), .nrst(nrst), .slow(slow), .go(go), .op(op), .cc(cc),
		.service(service), .wake(wake), .cmd(cmd), .srv_n(srv_n), .wake_n(wake_n),
		.last_vec(last_vec), .last_lvl(last_lvl));

	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		comparisons++;
		if (got !== exp) begin
			n_errors++;
			$display("MISMATCH %s expected %h seen %h", what, exp, got);
		end
	endtask

	task automatic wr(input logic [9:0] idx, input logic [7:0] d, input logic [1:0] er);
		logic a;
		logic b;
		int t;
		a = 1'b0;
		b = 1'b0;
		t = 0;
		@(posedge clk);
		awaddr <= {idx, 2'b00};
		wdata <= {24'h00_0000, d};
		awvalid <= 1'b1;
		wvalid <= 1'b1;
		bready <= 1'b1;
		while (!(a && b) && t < 50) begin
			@(posedge clk);
			t++;
			if (!a && awready) begin
				a = 1'b1;
				awvalid <= 1'b0;
			end
			if (!b && wready) begin
				b = 1'b1;
				wvalid <= 1'b0;
			end
		end
		do begin @(posedge clk); t++; end while (!bvalid && t < 100);
		chk("bresp", {30'h0, er}, {30'h0, bresp});
		bready <= 1'b0;
	endtask

	task automatic rd(input logic [9:0] idx, input logic [31:0] exp, input logic [1:0] er);
		int t;
		t = 0;
		@(posedge clk);
		araddr <= {idx, 2'b00};
		arvalid <= 1'b1;
		rready <= 1'b1;
		do begin @(posedge clk); t++; end while (!arready && t < 50);
		arvalid <= 1'b0;
		do begin @(posedge clk); t++; end while (!rvalid && t < 100);
		chk("rresp", {30'h0, er}, {30'h0, rresp});
		chk("rdata", exp, rdata);
		rready <= 1'b0;
	endtask

	task automatic cpu(input nic_pkg::nic_op_t o, input logic [7:0] c);
		@(posedge clk);
		op <= o;
		cc <= c;
		go <= 1'b1;
		@(posedge clk);
		go <= 1'b0;
		repeat (6) @(posedge clk);
	endtask

	task automatic lvl(input logic [1:0] e);
		chk("level", {30'h0, e}, {30'h0, lvl_hi, lvl_lo});
	endtask

	task automatic srv(input int n0, input logic [15:0] v, input logic [1:0] l);
		int t;
		t = 0;
		while (srv_n == n0 && t < 40) begin @(posedge clk); t++; end
		chk("vector", {16'h0000, v}, {16'h0000, last_vec});
		chk("svc level", {30'h0, l}, {30'h0, last_lvl});
	endtask

	task automatic clear(input logic [13:0] f, input logic [13:0] c);
		@(posedge clk);
		flag <= f;
		clr <= c;
		@(posedge clk);
		clr <= 14'h0000;
	endtask

	task automatic final_report;
		$display("comparisons %0d mismatches %0d", comparisons, n_errors);
		if (n_errors == 0 && comparisons > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask

	initial begin
		#400000;
		n_errors++;
		final_report;
	end

	initial begin
		repeat (3) @(posedge clk);
		nrst <= 1'b1;
		repeat (3) @(posedge clk);
		chk("vector", 32'h0000_FFFE, {16'h0000, last_vec});
		lvl(2'b11);
		rd(`NIC_IDX_PRIO0, 32'h0000_00FF, ok);
		rd(`NIC_IDX_PRIO3, 32'h0000_00FF, ok);
		rd(10'h02C, 32'h0000_0000, err);
		wr(10'h02C, 8'h55, err);
		wr(`NIC_IDX_PRIO3, 8'h00, ok);
		rd(`NIC_IDX_PRIO3, 32'h0000_00F0, ok);
		wr(`NIC_IDX_PRIO0, 8'hCF, ok);
		wr(`NIC_IDX_PRIO0, 8'h64, ok);
		rd(`NIC_IDX_PRIO0, 32'h0000_0044, ok);
		$display("test registers done");
		cpu(nic_pkg::NIC_OP_EI, 8'h00);
		lvl(2'b10);
		cpu(nic_pkg::NIC_OP_DI, 8'h00);
		lvl(2'b11);
		n = srv_n;
		cpu(nic_pkg::NIC_OP_TRAP, 8'h00);
		srv(n, 16'hFFFC, 2'b11);
		cpu(nic_pkg::NIC_OP_IRQ_RETURN_INSTR, 8'h20);
		rd(`NIC_IDX_LEVEL, 32'h0000_0020, ok);
		$display("test ops done");
		slow <= 1'b1;
		n = srv_n;
		clear(14'h3000, 14'h0000);
		repeat (8) @(posedge clk);
		chk("services", n, srv_n);
		en <= 14'h3120;
		srv(n, 16'hFFE2, 2'b00);
		lvl(2'b00);
		rd(`NIC_IDX_PEND, 32'h0000_3000, ok);
		clear(14'h2000, 14'h1000);
		rd(`NIC_IDX_PEND, 32'h0000_2000, ok);
		n = srv_n;
		cpu(nic_pkg::NIC_OP_IRQ_RETURN_INSTR, 8'h20);
		srv(n, 16'hFFE0, 2'b00);
		clear(14'h0000, 14'h2000);
		cpu(nic_pkg::NIC_OP_IRQ_RETURN_INSTR, 8'h20);
		slow <= 1'b0;
		$display("test peripherals done");
		n = srv_n;
		w = wake_n;
		cpu(nic_pkg::NIC_OP_WFI, 8'h00);
		lvl(2'b10);
		clear(14'h0020, 14'h0000);
		srv(n, 16'hFFF0, 2'b11);
		chk("wakes", w + 1, wake_n);
		clear(14'h0000, 14'h0020);
		cpu(nic_pkg::NIC_OP_IRQ_RETURN_INSTR, 8'h20);
		en <= 14'h0122;
		n = srv_n;
		w = wake_n;
		cpu(nic_pkg::NIC_OP_HALT, 8'h00);
		clear(14'h0022, 14'h0000);
		repeat (10) @(posedge clk);
		chk("wakes", w, wake_n);
		clear(14'h0122, 14'h0000);
		srv(n, 16'hFFEA, 2'b11);
		chk("wakes", w + 1, wake_n);
		clear(14'h0022, 14'h0100);
		n = srv_n;
		cpu(nic_pkg::NIC_OP_IRQ_RETURN_INSTR, 8'h20);
		srv(n, 16'hFFF0, 2'b11);
		clear(14'h0000, 14'h0022);
		cpu(nic_pkg::NIC_OP_IRQ_RETURN_INSTR, 8'h20);
		$display("test low power done");
		wr(`NIC_IDX_EXT_SENSE_CONTROL_REG, 8'h10, ok);
		n = srv_n;
		pins[3] <= 1'b0;
		srv(n, 16'hFFF4, 2'b01);
		rd(`NIC_IDX_PEND, 32'h0000_0000, ok);
		cpu(nic_pkg::NIC_OP_IRQ_RETURN_INSTR, 8'h20);
		n = srv_n;
		pins[4] <= 1'b0;
		srv(n, 16'hFFF4, 2'b01);
		cpu(nic_pkg::NIC_OP_IRQ_RETURN_INSTR, 8'h20);
		n = srv_n;
		forced[5] <= 1'b1;
		pins[5] <= 1'b0;
		repeat (10) @(posedge clk);
		chk("services", n, srv_n);
		cpu(nic_pkg::NIC_OP_DI, 8'h00);
		forced <= 10'h000;
		pins[6] <= 1'b0;
		repeat (8) @(posedge clk);
		rd(`NIC_IDX_PEND, 32'h0000_0008, ok);
		wr(`NIC_IDX_EXT_SENSE_CONTROL_REG, 8'h18, ok);
		rd(`NIC_IDX_PEND, 32'h0000_0000, ok);
		wr(`NIC_IDX_MMASK, 8'h01, ok);
		n = srv_n;
		speed_err <= 1'b1;
		@(posedge clk);
		speed_err <= 1'b0;
		srv(n, 16'hFFFA, 2'b11);
		repeat (4) @(posedge clk);
		n = srv_n;
		estop <= 1'b0;
		srv(n, 16'hFFFA, 2'b11);
		estop <= 1'b1;
		$display("test external done");
		final_report;
	end
endmodule

`default_nettype wire

// ---- test/nic_cpu_model.sv ----
`timescale 1ns/1ns
`default_nettype none

// Core sequencer stand-in. It ends an instruction every cycle, or every third cycle when slow,
// and hands one queued special op to the controller at the next instruction end.
module nic_cpu_model (
	input  wire logic                  clk,
	input  wire logic                  nrst,
	input  wire logic                  slow,
	input  wire logic                  go,
	input  wire nic_pkg::nic_op_t      op,
	input  wire logic [7:0]            cc,
	input  wire nic_pkg::nic_service_t service,
	input  wire logic                  wake,
	output nic_pkg::nic_cpu_cmd_t      cmd,
	output int                         srv_n,
	output int                         wake_n,
	output logic [15:0]                last_vec,
	output logic [1:0]                 last_lvl
);
	logic [1:0]       cnt;
	logic             have;
	nic_pkg::nic_op_t hold_op;
	logic [7:0]       hold_cc;

	always_ff @(posedge clk or negedge nrst) begin
		if (!nrst) begin
			cnt <= 2'h0;
			have <= 1'b0;
			hold_op <= nic_pkg::NIC_OP_NONE;
			hold_cc <= 8'h00;
			cmd <= '0;
			srv_n <= 0;
			wake_n <= 0;
			last_vec <= 16'h0000;
			last_lvl <= 2'h0;
		end else begin
			cnt <= (slow && cnt != 2'h2) ? cnt + 2'h1 : 2'h0;
			cmd.instr_end <= (cnt == 2'h0);
			cmd.op <= nic_pkg::NIC_OP_NONE;
			cmd.cc <= 8'h00;
			// Op and cc are only meaningful beside an instruction end, so they are zero elsewhere.
			if (go) begin
				have <= 1'b1;
				hold_op <= op;
				hold_cc <= cc;
			end else if (have && cnt == 2'h0) begin
				have <= 1'b0;
				cmd.op <= hold_op;
				cmd.cc <= hold_cc;
			end
			if (service.strobe) begin
				srv_n <= srv_n + 1;
				last_vec <= service.vector;
				last_lvl <= service.level;
			end
			if (wake) begin
				wake_n <= wake_n + 1;
			end
		end
	end
endmodule

`default_nettype wire
